// File: core/pwa_defs.vh
`ifndef PWA_DEFS_VH
`define PWA_DEFS_VH

// Clock rate of sys_clk in MHz
`define PWA_CLK_MHZ 200
// Length of the power-on clear pulse in clock cycles
`define PWA_POC_CYCLES 16
// Least closure stretch time in milliseconds
`define PWA_STRETCH_MS 10
// Stretch time as clock cycles, rounded up (whole cycles already)
`define PWA_STRETCH_CYCLES (`PWA_STRETCH_MS * `PWA_CLK_MHZ * 1000)
// Divider from sys_clk to the sequencer time base
`define PWA_SEQ_DIV 8
// Output word width and the width of each half latch
`define PWA_WORD_W 12
`define PWA_HALF_W 6

`endif

// File: core/pwa_input_shaper.v
`include "pwa_defs.vh"

// One input channel: synchroniser, edge capture, optional closure stretch
module pwa_input_shaper #(
	parameter STRETCH_CYCLES = `PWA_STRETCH_CYCLES
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Power-on clear, active high
	input wire power_on_clear,
	// Raw pin and closure option
	input wire pulse_pin,
	input wire contact_closure_option,
	// Request handshake with the arbiter
	input wire ack,
	output reg request,
	// Conditioned input level, high while asserted or stretched
	output reg level
);

	reg sync_a; // First synchroniser stage, read only by sync_b
	reg sync_b; // Second synchroniser stage
	reg prev; // Previous synchronised level for edge detection
	reg [31:0] stretch_cnt; // Remaining stretch cycles

	wire rise = sync_b & ~prev;
	// While stretching, further edges are bounce and are dropped
	wire stretching = (stretch_cnt != 32'h0000_0000);
	wire take = rise & ~(contact_closure_option & stretching);

	// Two-flop synchroniser on the pin
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync_a <= pulse_pin;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	// Closure stretch: hold the level for the least time after a closure
	always @(posedge sys_clk) begin
		if (!rst_n || power_on_clear) begin
			stretch_cnt <= 32'h0000_0000;
		end else if (contact_closure_option && take) begin
			stretch_cnt <= STRETCH_CYCLES;
		end else if (stretching) begin
			stretch_cnt <= stretch_cnt - 32'h0000_0001;
		end
	end

	// Conditioned level seen by the quiescence check
	always @(posedge sys_clk) begin
		if (!rst_n || power_on_clear) begin
			level <= 1'b0;
		end else begin
			level <= sync_b | (contact_closure_option & stretching);
		end
	end

	// Pending request; a new edge wins over a same-cycle acknowledge
	always @(posedge sys_clk) begin
		if (!rst_n || power_on_clear) begin
			request <= 1'b0;
		end else if (take) begin
			request <= 1'b1;
		end else if (ack) begin
			request <= 1'b0;
		end
	end

endmodule

// File: core/pwa_out_latch.v
`include "pwa_defs.vh"

// Half of the output latch: transparent until frozen, cleared by low clear
module pwa_out_latch #(
	parameter W = `PWA_HALF_W
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Active-low clear from the power-on clear
	input wire clear_n,
	// Transparent pass and load command
	input wire pass,
	input wire load,
	// Data in and held data out
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

	// Follow the data while passing, take it once on a load, else hold
	always @(posedge sys_clk) begin
		if (!rst_n || !clear_n) begin
			q <= {W{1'b0}};
		end else if (pass || load) begin
			q <= d;
		end
	end

endmodule

// File: core/pwa_top.v
`include "pwa_defs.vh"

// Summary of operation
// - Power-up issues active-high clear to shapers, counter
// - Inverted clear zeroes both six-bit latches
// - Two identical channels: count and update
// - Each input edge outside a stretch records a pending request
// - Closure option stretches input to least time
// - Arbiter starts one of two exclusive sequencers
// - Starting either sequencer resets the other
// - Sequencers advance only on internal time base
// - Counter counts up on inverted pulse fall
// - Counter accumulates until reset, then zero
// - Counter feeds two six-bit latches, twelve bits
// - First latch upper half, second lower half
// - Latches pass data until input quiescent
// - Latch command when quiescent freezes contents
module pwa_top #(
	parameter STRETCH_CYCLES = `PWA_STRETCH_CYCLES,
	parameter POC_CYCLES = `PWA_POC_CYCLES,
	parameter SEQ_DIV = `PWA_SEQ_DIV,
	parameter WORD_W = `PWA_WORD_W,
	parameter HALF_W = `PWA_HALF_W
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Input pins
	input wire count_pin,
	input wire update_pin,
	input wire contact_closure_option,
	// Output word for the ladder
	output wire [WORD_W-1:0] dac_word,
	// Status
	output reg power_on_clear,
	output reg seq_busy
);

	// Count sequencer states, one-hot
	localparam [2:0] C_IDLE = 3'h1;
	localparam [2:0] C_LOW = 3'h2;
	localparam [2:0] C_HIGH = 3'h4;
	// Update sequencer states, one-hot
	localparam [3:0] U_IDLE = 4'h1;
	localparam [3:0] U_WAIT = 4'h2;
	localparam [3:0] U_LATCH = 4'h4;
	localparam [3:0] U_CLR = 4'h8;

	reg [15:0] poc_cnt; // Cycles elapsed of the power-on clear
	reg poc_done; // Clear pulse has finished
	reg power_on_clear_n; // Inverted clear to the latches
	reg opt_a; // Option strap synchroniser, first stage
	reg opt_b; // Option strap, synchronised
	reg [7:0] div_cnt; // Time base divider
	reg tick; // One-cycle sequencer time base
	reg [2:0] cnt_state; // Count sequencer
	reg [3:0] upd_state; // Update sequencer
	reg prio_upd; // Round-robin: update wins next tie
	reg cnt_ack; // Acknowledge to the count channel
	reg upd_ack; // Acknowledge to the update channel
	reg count_pulse_n; // Inverted count pulse to the counter
	reg pulse_prev; // Previous inverted pulse, for fall detection
	reg [WORD_W-1:0] counter; // Binary accumulation counter
	reg pass; // Latches transparent after power-on
	reg latch_cmd; // One-cycle freeze command
	reg next_prio_upd; // Arbiter outcome for the priority flag
	reg start_cnt; // Arbiter grants a count sequence
	reg start_upd; // Arbiter grants an update sequence

	wire cnt_req;
	wire upd_req;
	// Only the count channel's level decides quiescence
	wire cnt_level;

	// Power-on clear: held high for a fixed time after reset release
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			poc_cnt <= 16'h0000;
			poc_done <= 1'b0;
			power_on_clear <= 1'b1;
			power_on_clear_n <= 1'b0;
		end else if (!poc_done) begin
			poc_cnt <= poc_cnt + 16'h0001;
			if (poc_cnt == POC_CYCLES[15:0] - 16'h0001) begin
				poc_done <= 1'b1;
				power_on_clear <= 1'b0;
				power_on_clear_n <= 1'b1;
			end
		end
	end

	// Synchronise the option strap, it comes from a pin
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			opt_a <= 1'b0;
			opt_b <= 1'b0;
		end else begin
			opt_a <= contact_closure_option;
			opt_b <= opt_a;
		end
	end

	// Two identical channels, one per external source
	pwa_input_shaper #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_count_ch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.power_on_clear(power_on_clear),
		.pulse_pin(count_pin),
		.contact_closure_option(opt_b),
		.ack(cnt_ack),
		.request(cnt_req),
		.level(cnt_level)
	);

	// Update level is left open: a long update closure cannot hold off the freeze
	// The request path is all that the update sequencer needs from this channel
	pwa_input_shaper #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_update_ch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.power_on_clear(power_on_clear),
		.pulse_pin(update_pin),
		.contact_closure_option(opt_b),
		.ack(upd_ack),
		.request(upd_req),
		.level()
	);

	// Free-running time base; sequencers move only on its tick
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (div_cnt == SEQ_DIV[7:0] - 8'h01) begin
			div_cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			tick <= 1'b0;
		end
	end

	// Arbiter: grants one request on a tick while both sequencers rest
	always @* begin
		start_cnt = 1'b0;
		start_upd = 1'b0;
		next_prio_upd = prio_upd;
		if (tick && !power_on_clear && cnt_state == C_IDLE && upd_state == U_IDLE) begin
			// A tie goes to the side whose turn it is; the loser stays pending
			if (upd_req && (!cnt_req || prio_upd)) begin
				start_upd = 1'b1;
				next_prio_upd = 1'b0;
			end else if (cnt_req) begin
				start_cnt = 1'b1;
				next_prio_upd = 1'b1;
			end
		end
	end

	// Acknowledges and the fairness flag
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			prio_upd <= 1'b0;
			cnt_ack <= 1'b0;
			upd_ack <= 1'b0;
		end else begin
			prio_upd <= next_prio_upd;
			cnt_ack <= start_cnt;
			upd_ack <= start_upd;
		end
	end

	// Count sequencer: one low then high inverted pulse per request
	always @(posedge sys_clk) begin
		if (!rst_n || power_on_clear) begin
			cnt_state <= C_IDLE;
			count_pulse_n <= 1'b1;
		end else if (start_upd) begin
			cnt_state <= C_IDLE;
			count_pulse_n <= 1'b1;
		end else if (start_cnt) begin
			cnt_state <= C_LOW;
			count_pulse_n <= 1'b0;
		end else if (tick) begin
			case (cnt_state)
				C_LOW: begin
					cnt_state <= C_HIGH;
					count_pulse_n <= 1'b1;
				end
				C_HIGH: begin
					cnt_state <= C_IDLE;
				end
				C_IDLE: begin
					cnt_state <= C_IDLE;
				end
				default: begin
					cnt_state <= C_IDLE;
					count_pulse_n <= 1'b1;
				end
			endcase
		end
	end

	// Update sequencer: wait quiescent, freeze latches, then clear counter
	always @(posedge sys_clk) begin
		if (!rst_n || power_on_clear) begin
			upd_state <= U_IDLE;
			latch_cmd <= 1'b0;
		end else if (start_cnt) begin
			upd_state <= U_IDLE;
			latch_cmd <= 1'b0;
		end else if (start_upd) begin
			upd_state <= U_WAIT;
			latch_cmd <= 1'b0;
		end else if (tick) begin
			latch_cmd <= 1'b0;
			case (upd_state)
				U_WAIT: begin
					// A stretched closure is still counted as active input
					if (!cnt_level) begin
						upd_state <= U_LATCH;
						latch_cmd <= 1'b1;
					end
				end
				U_LATCH: begin
					upd_state <= U_CLR;
				end
				U_CLR: begin
					upd_state <= U_IDLE;
				end
				U_IDLE: begin
					upd_state <= U_IDLE;
				end
				default: begin
					upd_state <= U_IDLE;
				end
			endcase
		end else begin
			latch_cmd <= 1'b0;
		end
	end

	// Busy flag shows either sequencer running
	// Registered, so it trails the sequencer states by one cycle
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			seq_busy <= 1'b0;
		end else begin
			seq_busy <= (cnt_state != C_IDLE) || (upd_state != U_IDLE);
		end
	end

	// Counter: up on each fall of the inverted pulse, zero on clear
	// Edge detection means a held low pulse can never count twice
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			pulse_prev <= 1'b1;
			counter <= {WORD_W{1'b0}};
		end else begin
			pulse_prev <= count_pulse_n;
			if (power_on_clear) begin
				counter <= {WORD_W{1'b0}};
			end else if (tick && upd_state == U_CLR) begin
				counter <= {WORD_W{1'b0}};
			end else if (pulse_prev && !count_pulse_n) begin
				counter <= counter + {{(WORD_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Latches run transparent from power-on until the first freeze
	always @(posedge sys_clk) begin
		if (!rst_n || power_on_clear) begin
			pass <= 1'b1;
		end else if (latch_cmd) begin
			pass <= 1'b0;
		end
	end

	// Upper half, holding the most significant bit
	pwa_out_latch #(.W(HALF_W)) u_latch_hi (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clear_n(power_on_clear_n),
		.pass(pass),
		.load(latch_cmd),
		.d(counter[WORD_W-1:HALF_W]),
		.q(dac_word[WORD_W-1:HALF_W])
	);

	// Lower half, ending at the least significant bit
	pwa_out_latch #(.W(HALF_W)) u_latch_lo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clear_n(power_on_clear_n),
		.pass(pass),
		.load(latch_cmd),
		.d(counter[HALF_W-1:0]),
		.q(dac_word[HALF_W-1:0])
	);

endmodule

// File: tb/pwa_src_model.sv
// Far side: pulse source on one line, update command source on the other
module pwa_src_model (
	// Clock
	input logic sys_clk,
	// Pulse lines toward the block, idle low
	output logic count_pin,
	output logic update_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines rest low so the first closure gives a clean rising edge
	initial begin
		count_pin = 1'b0;
		update_pin = 1'b0;
	end

	// One pulse on either or both lines, hi cycles wide, moved on falling edges
	task automatic pulse(input logic cnt, input logic upd, input int hi);
		@(negedge sys_clk);
		count_pin = cnt;
		update_pin = upd;
		repeat (hi) @(negedge sys_clk);
		count_pin = 1'b0;
		update_pin = 1'b0;
	endtask

	// Bouncing contact: short closures far inside the stretch time
	task automatic bounce(input int n);
		repeat (n) begin
			pulse(1'b1, 1'b0, 2);
			repeat (2) @(negedge sys_clk);
		end
	endtask
endmodule

// File: tb/pwa_top_sva.sv
// Port-level checks of the accumulator top
module pwa_top_sva #(
	parameter WORD_W = 12
) (
	// Clock and reset
	input logic sys_clk,
	input logic rst_n,
	// Pins
	input logic count_pin,
	input logic update_pin,
	input logic contact_closure_option,
	// Outputs
	input logic [WORD_W-1:0] dac_word,
	input logic power_on_clear,
	input logic seq_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// Grace for a request: sync, tick wait and one other sequence ahead
	localparam int REQ_MAX = 80;
	// Longest busy run: two sequences back to back with margin
	localparam int BUSY_MAX = 200;
	int busy_run;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Length of the current busy stretch
	always @(posedge sys_clk) begin
		if (!rst_n || !seq_busy) begin
			busy_run <= 0;
		end else begin
			busy_run <= busy_run + 1;
		end
	end

	property p_poc_release;
		$rose(rst_n) |-> power_on_clear [*8] ##1 power_on_clear [*8] ##1 !power_on_clear;
	endproperty
	a_poc_release: assert property (p_poc_release) else $error("clear pulse length wrong");
	property p_poc_once;
		!power_on_clear |=> !power_on_clear;
	endproperty
	a_poc_once: assert property (p_poc_once) else $error("clear came back");
	property p_poc_zero;
		power_on_clear |-> dac_word == '0;
	endproperty
	a_poc_zero: assert property (p_poc_zero) else $error("word not zero in clear");
	property p_poc_idle;
		power_on_clear |-> !seq_busy;
	endproperty
	a_poc_idle: assert property (p_poc_idle) else $error("busy during clear");
	property p_dac_busy;
		$changed(dac_word) |-> seq_busy || $past(seq_busy);
	endproperty
	a_dac_busy: assert property (p_dac_busy) else $error("word moved while idle");
	property p_cnt_req;
		$rose(count_pin) && !power_on_clear && !contact_closure_option
			|-> ##[3:REQ_MAX] seq_busy;
	endproperty
	a_cnt_req: assert property (p_cnt_req) else $error("count edge not served");
	property p_upd_req;
		$rose(update_pin) && !power_on_clear |-> ##[3:REQ_MAX] seq_busy;
	endproperty
	a_upd_req: assert property (p_upd_req) else $error("update edge not served");
	property p_busy_bound;
		busy_run < BUSY_MAX;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("sequencer stuck busy");

	c_poc_fell: cover property ($fell(power_on_clear));
	c_dac_move: cover property ($changed(dac_word));
	c_tie: cover property ($rose(count_pin) && $rose(update_pin));
endmodule

// File: tb/testbench.sv
// Top bench: drives the block through its pins and checks the held word
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// Short closure stretch keeps the run brief
	localparam int STRETCH = 50;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic contact_closure_option = 1'b0;
	wire count_pin;
	wire update_pin;
	wire [11:0] dac_word;
	wire power_on_clear;
	wire seq_busy;
	int miscompares = 0;
	int num_checks = 0;
	logic [11:0] first_val;

	pwa_src_model u_src (.sys_clk(sys_clk), .count_pin(count_pin), .update_pin(update_pin));
	pwa_top #(.STRETCH_CYCLES(STRETCH)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .count_pin(count_pin), .update_pin(update_pin),
		.contact_closure_option(contact_closure_option), .dac_word(dac_word),
		.power_on_clear(power_on_clear), .seq_busy(seq_busy));

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	// Counts, then the verdict
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Four-state compare of the output word
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Four-state compare of a one-bit status flag
	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Wait until the sequencers stay idle long enough to cover a pending request
	task automatic settle;
		int quiet;
		quiet = 0;
		for (int i = 0; i < 400 && quiet < 40; i++) begin
			@(negedge sys_clk);
			quiet = (seq_busy === 1'b0) ? quiet + 1 : 0;
		end
		if (quiet < 40) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	// Reset for five cycles, then time the clear pulse
	task automatic t_reset;
		@(negedge sys_clk);
		rst_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk(dac_word, 12'h000);
		chk_flag(power_on_clear, 1'b1);
		chk_flag(seq_busy, 1'b0);
		rst_n = 1'b1;
		repeat (15) @(negedge sys_clk);
		chk_flag(power_on_clear, 1'b1);
		@(negedge sys_clk);
		chk_flag(power_on_clear, 1'b0);
	endtask

	// 70 counts cross the half boundary while latches are transparent
	task automatic t_count_many;
		repeat (70) begin
			u_src.pulse(1'b1, 1'b0, 4);
			settle();
		end
		chk(dac_word, 12'h046);
	endtask

	// Update captures, freezes, and opens a fresh window from zero
	task automatic t_update_freeze;
		u_src.pulse(1'b0, 1'b1, 4);
		settle();
		chk(dac_word, 12'h046);
		repeat (5) begin
			u_src.pulse(1'b1, 1'b0, 4);
			settle();
		end
		chk(dac_word, 12'h046);
		u_src.pulse(1'b0, 1'b1, 4);
		settle();
		chk(dac_word, 12'h005);
	endtask

	// A bouncing closure counts once with the option on
	task automatic t_bounce;
		contact_closure_option = 1'b1;
		settle();
		u_src.bounce(3);
		repeat (2 * STRETCH) @(negedge sys_clk);
		settle();
		u_src.pulse(1'b0, 1'b1, 4);
		settle();
		chk(dac_word, 12'h001);
		contact_closure_option = 1'b0;
	endtask

	// Tie: whichever order is served, the one count shows over two updates
	task automatic t_tie;
		u_src.pulse(1'b1, 1'b1, 4);
		settle();
		first_val = dac_word;
		u_src.pulse(1'b0, 1'b1, 4);
		settle();
		chk(first_val + dac_word, 12'h001);
	endtask

	// Main sequence; the second reset checks clearing of a held word
	initial begin
		t_reset();
		t_count_many();
		t_update_freeze();
		t_reset();
		t_bounce();
		t_tie();
		report_and_stop();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end
endmodule

bind pwa_top pwa_top_sva #(.WORD_W(WORD_W)) u_sva (
	.sys_clk(sys_clk), .rst_n(rst_n), .count_pin(count_pin), .update_pin(update_pin),
	.contact_closure_option(contact_closure_option), .dac_word(dac_word),
	.power_on_clear(power_on_clear), .seq_busy(seq_busy));
